// ===== hdl/bsm_pkg.sv
// shared constants and types of the strap and control register block
package bsm_pkg;
	// register word offsets (byte addresses)
	localparam logic [7:0] OFS_MISC_CONTROL        = 8'h00;
	localparam logic [7:0] OFS_MISC_CONTROL_SECOND = 8'h04;
	localparam logic [7:0] OFS_PCI_ARBITER_CONTROL = 8'h08;
	localparam logic [7:0] OFS_PCI_COMMAND_STATUS  = 8'h0C;
	localparam logic [7:0] OFS_IMAGE0_CONTROL      = 8'h10;
	localparam logic [7:0] OFS_IMAGE1_CONTROL      = 8'h14;
	// misc_control fields
	localparam int MC_PROTO_LSB    = 0;
	localparam int MC_BYTE_ORDER   = 2;
	localparam int MC_SW_RESET     = 3;
	localparam int MC_MA_RESPONSE  = 4;
	localparam int MC_TARGET_PREFETCH_COUNT_LSB    = 8;
	localparam int MC_EEPROM_USE   = 12;
	localparam int MC_TEST_LSB     = 13;
	// misc_control_second fields
	localparam int MC2_PCI_DISABLE = 0;
	localparam int MC2_PER_IMAGE   = 1;
	localparam int MC2_HOLD_BUS    = 2;
	localparam int MC2_RETRY_LSB   = 3;
	localparam int MC2_SLOW_DISC   = 5;
	localparam int MC2_TA_ERROR    = 6;
	localparam int MC2_BURST_FOUR  = 7;
	localparam int MC2_SINGLE_BEAT = 8;
	localparam int MC2_NO_ORDER    = 9;
	localparam int MC2_PRCNT1_LSB  = 16;
	// pci_arbiter_control fields
	localparam int ARB_PRI_LSB     = 0;
	localparam int ARB_OWN_PRI     = 8;
	localparam int ARB_ENABLE      = 9;
	localparam int ARB_PARK        = 10;
	localparam int ARB_PARK_LSB    = 12;
	// pci command/status and image control fields
	localparam int PCS_BUS_MASTER  = 2;
	localparam int IMG_INVERT      = 0;
	localparam int IMG_BURST_WR    = 1;
	// field widths
	localparam int TARGET_PREFETCH_COUNT_W         = 4;
	localparam int PRCNT1_W        = 6;
	localparam int RETRY_W         = 2;
	localparam int PARK_W          = 3;
	localparam int NUM_IMAGES      = 2;
	// slow target limit in pci clocks
	localparam int SLOW_TARGET_CLOCKS = 8;
	// clocks from a reset pin rising to the straps landing in the device
	localparam int STRAP_CAPTURE_DELAY = 3;
	// reset value of every writable field
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	// processor bus protocol selected by straps
	typedef enum logic [1:0] {
		BSM_PROTO_BURST_BUS,
		BSM_PROTO_TYPE40,
		BSM_PROTO_OTHER
	} bsm_proto_t;
endpackage

// ===== hdl/bsm_link_if.sv
// link between the bridge configuration block and its local master
`timescale 1ns/1ps
interface bsm_link_if;
	logic        burst_in_progress_strap;
	logic        transfer_size_bit1_strap;
	logic        bus_master_strap;
	logic        arbiter_enable_strap;
	logic        pci_disable_strap;
	logic        serial_data_strap;
	logic        eeprom_use_strap;
	logic [1:0]  test_mode_straps;
	logic        pci_reset_n;
	logic        local_reset_input_n;
	logic        local_reset_output_n;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;

	modport device (
		input  burst_in_progress_strap, transfer_size_bit1_strap, bus_master_strap,
		input  arbiter_enable_strap, pci_disable_strap, serial_data_strap,
		input  eeprom_use_strap, test_mode_straps, pci_reset_n, local_reset_input_n,
		input  reg_addr, reg_wdata, reg_wr, reg_rd,
		output local_reset_output_n, reg_rdata
	);
	modport host (
		output burst_in_progress_strap, transfer_size_bit1_strap, bus_master_strap,
		output arbiter_enable_strap, pci_disable_strap, serial_data_strap,
		output eeprom_use_strap, test_mode_straps, pci_reset_n, local_reset_input_n,
		output reg_addr, reg_wdata, reg_wr, reg_rd,
		input  local_reset_output_n, reg_rdata
	);
endinterface

// ===== hdl/bsm_sync.sv
// two-flop pin synchroniser with rising edge detect
`timescale 1ns/1ps
module bsm_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk_in,
	input  wire logic         resetn_in,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level_out,
	output logic      [W-1:0] rise_out
);
	logic [W-1:0] stage1;
	logic [W-1:0] prev;

	// stage1 feeds only level_out; edges are taken from the settled level
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			stage1    <= '0;
			level_out <= '0;
			prev      <= '0;
		end else begin
			stage1    <= pin_in;
			level_out <= stage1;
			prev      <= level_out;
		end
	end

	assign rise_out = level_out & ~prev;
endmodule // bsm_sync

// ===== hdl/bsm_device.sv
// bridge strap capture and miscellaneous control registers
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
module bsm_device
	import bsm_pkg::*;
#(
	parameter int NUM_MASTERS = 4
) (
	input  wire logic                      ref_clk_in,
	input  wire logic                      resetn_in,
	bsm_link_if.device                     link,
	output bsm_proto_t                     protocol_out,
	output logic                           eeprom_use_out,
	output logic [1:0]                     test_mode_out,
	output logic                           initiator_enable_out,
	output logic                           arbiter_enable_out,
	output logic                           target_retry_out,
	output logic                           master_abort_response_out,
	output logic [NUM_IMAGES-1:0]          image_big_endian_out,
	output logic [NUM_IMAGES*PRCNT1_W-1:0] image_prefetch_count_out,
	output logic                           hold_local_bus_out,
	output logic [RETRY_W-1:0]             retry_limit_out,
	output logic                           slow_target_disconnect_out,
	output logic                           target_abort_error_out,
	output logic [NUM_IMAGES-1:0]          image_local_burst_out,
	output logic                           single_beat_prefetch_out,
	output logic                           ordering_rule_disable_out,
	output logic [NUM_MASTERS-1:0]         master_priority_out,
	output logic                           own_priority_out,
	output logic                           park_enable_out,
	output logic [PARK_W-1:0]              parked_master_out
);
	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	localparam int NPIN = 11;
	logic [NPIN-1:0] pin_lvl;
	logic [NPIN-1:0] pin_rise;

	bsm_sync #(.W(NPIN)) u_sync (
		.ref_clk_in (ref_clk_in),
		.resetn_in  (resetn_in),
		.pin_in     ({link.pci_reset_n, link.local_reset_input_n,
		              link.burst_in_progress_strap, link.transfer_size_bit1_strap,
		              link.bus_master_strap, link.arbiter_enable_strap,
		              link.pci_disable_strap, link.serial_data_strap,
		              link.eeprom_use_strap, link.test_mode_straps}),
		.level_out  (pin_lvl),
		.rise_out   (pin_rise)
	);

	logic pci_reset_active;
	logic reset_event;
	assign pci_reset_active = ~pin_lvl[10];
	assign reset_event      = pin_rise[10] | pin_rise[9];

	////////////////////////////////////////////////////////////////////////
	// strap capture; values stand until the next reset event
	bsm_proto_t proto;
	logic       eeprom_use;
	logic [1:0] test_mode;

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			proto      <= BSM_PROTO_BURST_BUS;
			eeprom_use <= 1'b0;
			test_mode  <= 2'h0;
		end else if (reset_event) begin
			if (pin_lvl[8] && !pin_lvl[7])
				proto <= BSM_PROTO_TYPE40;
			else if (!pin_lvl[7])
				proto <= BSM_PROTO_BURST_BUS;
			else
				proto <= BSM_PROTO_OTHER;
			eeprom_use <= pin_lvl[3] & pin_lvl[2];
			test_mode  <= pin_lvl[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register strobes
	logic wr_mc;
	logic wr_mc2;
	logic wr_arb;
	logic wr_pcs;
	logic [NUM_IMAGES-1:0] wr_img;
	assign wr_mc  = link.reg_wr && link.reg_addr == OFS_MISC_CONTROL;
	assign wr_mc2 = link.reg_wr && link.reg_addr == OFS_MISC_CONTROL_SECOND;
	assign wr_arb = link.reg_wr && link.reg_addr == OFS_PCI_ARBITER_CONTROL;
	assign wr_pcs = link.reg_wr && link.reg_addr == OFS_PCI_COMMAND_STATUS;
	assign wr_img[0] = link.reg_wr && link.reg_addr == OFS_IMAGE0_CONTROL;
	assign wr_img[1] = link.reg_wr && link.reg_addr == OFS_IMAGE1_CONTROL;

	////////////////////////////////////////////////////////////////////////
	// strap-loaded control bits; a reset event wins over a software write
	logic initiator_enable;
	logic arbiter_enable;
	logic pci_disable;

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			initiator_enable <= 1'b0;
			arbiter_enable   <= 1'b0;
			pci_disable      <= 1'b0;
		end else if (reset_event) begin
			initiator_enable <= pin_lvl[6];
			arbiter_enable   <= pin_lvl[5];
			pci_disable      <= pin_lvl[4];
		end else begin
			if (wr_pcs)
				initiator_enable <= link.reg_wdata[PCS_BUS_MASTER];
			// write one clears the disable status
			if (wr_mc2 && link.reg_wdata[MC2_PCI_DISABLE])
				pci_disable <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// software control fields
	logic                   byte_order;
	logic                   sw_reset;
	logic                   ma_response;
	logic [TARGET_PREFETCH_COUNT_W-1:0]     target_prefetch_count;
	logic [31:0]            mc2;
	logic [NUM_MASTERS-1:0] m_pri;
	logic                   own_pri;
	logic                   park;
	logic [PARK_W-1:0]      park_sel;
	logic [NUM_IMAGES-1:0]  img_invert;
	logic [NUM_IMAGES-1:0]  img_burst_wr;

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			byte_order  <= 1'b0;
			sw_reset    <= 1'b0;
			ma_response <= 1'b0;
			target_prefetch_count       <= '0;
		end else if (wr_mc) begin
			byte_order  <= link.reg_wdata[MC_BYTE_ORDER];
			sw_reset    <= link.reg_wdata[MC_SW_RESET];
			ma_response <= link.reg_wdata[MC_MA_RESPONSE];
			target_prefetch_count       <= link.reg_wdata[MC_TARGET_PREFETCH_COUNT_LSB +: TARGET_PREFETCH_COUNT_W];
		end
	end

	// disable status bit lives in pci_disable, so it is masked out here
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			mc2 <= REG_RESET;
		else if (wr_mc2)
			mc2 <= link.reg_wdata & 32'h003F_03FE;
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			m_pri    <= '0;
			own_pri  <= 1'b0;
			park     <= 1'b0;
			park_sel <= '0;
		end else if (wr_arb) begin
			m_pri    <= link.reg_wdata[ARB_PRI_LSB +: NUM_MASTERS];
			own_pri  <= link.reg_wdata[ARB_OWN_PRI];
			park     <= link.reg_wdata[ARB_PARK];
			park_sel <= link.reg_wdata[ARB_PARK_LSB +: PARK_W];
		end
	end

	// per-image control words
	genvar gi;
	generate
		for (gi = 0; gi < NUM_IMAGES; gi++) begin : g_img
			always_ff @(posedge ref_clk_in or negedge resetn_in) begin
				if (!resetn_in) begin
					img_invert[gi]   <= 1'b0;
					img_burst_wr[gi] <= 1'b0;
				end else if (wr_img[gi]) begin
					img_invert[gi]   <= link.reg_wdata[IMG_INVERT];
					img_burst_wr[gi] <= link.reg_wdata[IMG_BURST_WR];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// read port: data stand in the cycle after the read strobe
	function automatic logic [31:0] read_word(input logic [7:0] a);
		logic [31:0] w;
		w = 32'h0000_0000;
		unique case (a)
			OFS_MISC_CONTROL: begin
				w[MC_PROTO_LSB +: 2]       = proto;
				w[MC_BYTE_ORDER]           = byte_order;
				w[MC_SW_RESET]             = sw_reset;
				w[MC_MA_RESPONSE]          = ma_response;
				w[MC_TARGET_PREFETCH_COUNT_LSB +: TARGET_PREFETCH_COUNT_W] = target_prefetch_count;
				w[MC_EEPROM_USE]           = eeprom_use;
				w[MC_TEST_LSB +: 2]        = test_mode;
			end
			OFS_MISC_CONTROL_SECOND: w = mc2 | {31'h0, pci_disable};
			OFS_PCI_ARBITER_CONTROL: begin
				w[ARB_PRI_LSB +: NUM_MASTERS] = m_pri;
				w[ARB_OWN_PRI]                = own_pri;
				w[ARB_ENABLE]                 = arbiter_enable;
				w[ARB_PARK]                   = park;
				w[ARB_PARK_LSB +: PARK_W]     = park_sel;
			end
			OFS_PCI_COMMAND_STATUS: w[PCS_BUS_MASTER] = initiator_enable;
			OFS_IMAGE0_CONTROL: w[1:0] = {img_burst_wr[0], img_invert[0]};
			OFS_IMAGE1_CONTROL: w[1:0] = {img_burst_wr[1], img_invert[1]};
			default: w = 32'h0000_0000; // unmapped reads zero
		endcase
		return w;
	endfunction

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			link.reg_rdata <= 32'h0000_0000;
		else if (link.reg_rd)
			link.reg_rdata <= read_word(link.reg_addr);
		else
			link.reg_rdata <= 32'h0000_0000;
	end

	////////////////////////////////////////////////////////////////////////
	// local reset output follows pci reset or the software reset bit
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			link.local_reset_output_n <= 1'b0;
		else
			link.local_reset_output_n <= ~(sw_reset | pci_reset_active);
	end

	////////////////////////////////////////////////////////////////////////
	// registered decoded controls for the channels
	logic burst_bus;
	assign burst_bus = proto == BSM_PROTO_BURST_BUS;

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			protocol_out               <= BSM_PROTO_BURST_BUS;
			eeprom_use_out             <= 1'b0;
			test_mode_out              <= 2'h0;
			initiator_enable_out       <= 1'b0;
			arbiter_enable_out         <= 1'b0;
			target_retry_out           <= 1'b0;
			master_abort_response_out  <= 1'b0;
			hold_local_bus_out         <= 1'b0;
			retry_limit_out            <= '0;
			slow_target_disconnect_out <= 1'b0;
			target_abort_error_out     <= 1'b0;
			single_beat_prefetch_out   <= 1'b0;
			ordering_rule_disable_out  <= 1'b0;
			master_priority_out        <= '0;
			own_priority_out           <= 1'b0;
			park_enable_out            <= 1'b0;
			parked_master_out          <= '0;
		end else begin
			protocol_out               <= proto;
			eeprom_use_out             <= eeprom_use;
			test_mode_out              <= test_mode;
			initiator_enable_out       <= initiator_enable;
			arbiter_enable_out         <= arbiter_enable;
			target_retry_out           <= pci_disable;
			master_abort_response_out  <= ma_response;
			hold_local_bus_out         <= mc2[MC2_HOLD_BUS];
			retry_limit_out            <= mc2[MC2_RETRY_LSB +: RETRY_W];
			// channel counts SLOW_TARGET_CLOCKS before disconnecting
			slow_target_disconnect_out <= mc2[MC2_SLOW_DISC];
			target_abort_error_out     <= mc2[MC2_TA_ERROR];
			single_beat_prefetch_out   <= mc2[MC2_SINGLE_BEAT] & burst_bus;
			ordering_rule_disable_out  <= mc2[MC2_NO_ORDER];
			master_priority_out        <= m_pri;
			own_priority_out           <= own_pri;
			park_enable_out            <= park;
			parked_master_out          <= park_sel;
		end
	end

	// per-image endian, prefetch count and burst permission
	generate
		for (gi = 0; gi < NUM_IMAGES; gi++) begin : g_out
			always_ff @(posedge ref_clk_in or negedge resetn_in) begin
				if (!resetn_in) begin
					image_big_endian_out[gi]                     <= 1'b0;
					image_prefetch_count_out[gi*PRCNT1_W +: PRCNT1_W] <= '0;
					image_local_burst_out[gi]                    <= 1'b0;
				end else begin
					image_big_endian_out[gi] <= byte_order ^ img_invert[gi];
					// shared count unless per-image mode picks the second field
					image_prefetch_count_out[gi*PRCNT1_W +: PRCNT1_W] <=
						(gi == 1 && mc2[MC2_PER_IMAGE]) ?
						mc2[MC2_PRCNT1_LSB +: PRCNT1_W] :
						{{(PRCNT1_W-TARGET_PREFETCH_COUNT_W){1'b0}}, target_prefetch_count};
					image_local_burst_out[gi] <=
						mc2[MC2_BURST_FOUR] & img_burst_wr[gi] & burst_bus;
				end
			end
		end
	endgenerate
endmodule // bsm_device

// ===== hdl/bsm_host.sv
// local master end: drives straps and resets, relays register commands
`timescale 1ns/1ps
module bsm_host
	import bsm_pkg::*;
(
	input  wire logic        ref_clk_in,
	input  wire logic        resetn_in,
	bsm_link_if.host         link,
	input  wire logic        pci_reset_req_in,
	input  wire logic        local_reset_req_in,
	input  wire logic        type40_mode_in,
	input  wire logic        bus_master_strap_in,
	input  wire logic        arbiter_enable_in,
	input  wire logic        pci_disable_in,
	input  wire logic        eeprom_fitted_in,
	input  wire logic [1:0]  test_mode_req_in,
	input  wire logic [7:0]  cmd_addr_in,
	input  wire logic [31:0] cmd_wdata_in,
	input  wire logic        cmd_wr_in,
	input  wire logic        cmd_rd_in,
	output logic [31:0]      cmd_rdata_out,
	output logic             init_busy_out,
	output logic             local_reset_seen_out
);
	typedef enum logic [1:0] {BSM_H_IDLE, BSM_H_PEND, BSM_H_WRITE} bsm_host_state_t;
	bsm_host_state_t state;
	logic            pci_reset_q;
	logic [2:0]      pend_cnt;

	// strap and reset pins come from flops so they never glitch
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			link.pci_reset_n              <= 1'b0;
			link.local_reset_input_n      <= 1'b0;
			link.burst_in_progress_strap  <= 1'b0;
			link.transfer_size_bit1_strap <= 1'b0;
			link.bus_master_strap         <= 1'b0;
			link.arbiter_enable_strap     <= 1'b0;
			link.pci_disable_strap        <= 1'b0;
			link.serial_data_strap        <= 1'b0;
			link.eeprom_use_strap         <= 1'b0;
			link.test_mode_straps         <= 2'h0;
			pci_reset_q                   <= 1'b1;
		end else begin
			link.pci_reset_n              <= ~pci_reset_req_in;
			link.local_reset_input_n      <= ~local_reset_req_in;
			link.burst_in_progress_strap  <= type40_mode_in;
			link.transfer_size_bit1_strap <= 1'b0;
			link.bus_master_strap         <= bus_master_strap_in;
			link.arbiter_enable_strap     <= arbiter_enable_in;
			link.pci_disable_strap        <= pci_disable_in;
			link.serial_data_strap        <= eeprom_fitted_in;
			link.eeprom_use_strap         <= eeprom_fitted_in;
			link.test_mode_straps         <= test_mode_req_in;
			pci_reset_q                   <= pci_reset_req_in;
		end
	end

	// after pci reset ends with the strap low, software enables initiator
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			state <= BSM_H_IDLE;
		else
			unique case (state)
				BSM_H_IDLE: begin
					if (pci_reset_q && !pci_reset_req_in && !bus_master_strap_in)
						state <= BSM_H_PEND;
				end
				// wait out the device's strap capture latency
				BSM_H_PEND: begin
					if (pend_cnt == 3'(STRAP_CAPTURE_DELAY))
						state <= BSM_H_WRITE;
				end
				BSM_H_WRITE: begin
					if (!cmd_wr_in && !cmd_rd_in)
						state <= BSM_H_IDLE;
				end
			endcase
	end

	// a write landing before the capture would be overwritten by the low strap
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			pend_cnt <= 3'h0;
		else if (state == BSM_H_PEND)
			pend_cnt <= pend_cnt + 3'h1;
		else
			pend_cnt <= 3'h0;
	end

	logic init_go;
	assign init_go = state == BSM_H_WRITE && !cmd_wr_in && !cmd_rd_in;

	// user commands pass straight through; the init write fills an idle slot
	always_comb begin
		link.reg_addr  = cmd_addr_in;
		link.reg_wdata = cmd_wdata_in;
		link.reg_wr    = cmd_wr_in;
		link.reg_rd    = cmd_rd_in;
		if (init_go) begin
			link.reg_addr  = OFS_PCI_COMMAND_STATUS;
			link.reg_wdata = 32'h0000_0001 << PCS_BUS_MASTER;
			link.reg_wr    = 1'b1;
		end
	end

	assign cmd_rdata_out = link.reg_rdata;
	assign init_busy_out = state != BSM_H_IDLE;

	// local reset output is a pin from the device, so it is synchronised
	logic rst_s1;
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_s1               <= 1'b0;
			local_reset_seen_out <= 1'b1;
		end else begin
			rst_s1               <= ~link.local_reset_output_n;
			local_reset_seen_out <= rst_s1;
		end
	end
endmodule // bsm_host

// ===== bench/bsm_link_properties.sv
// concurrent checks on the register and reset wires between the two ends
`timescale 1ns/1ps
module bsm_link_properties
	import bsm_pkg::*;
(
	input wire logic        ref_clk_in,
	input wire logic        resetn_in,
	input wire logic        pci_reset_n,
	input wire logic        local_reset_output_n,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata
);
	// one clock domain, so clocking and reset are given once
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!resetn_in);
	////////////////////////////////////////////////////////////////////////
	// read data stands one cycle only, an idle bus reads zero
	AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data not idle");
	// unused bits of the two misc control words read zero
	AST_MC_RSV: assert property (reg_rd && reg_addr == OFS_MISC_CONTROL
		|=> (reg_rdata & 32'hFFFF_80E0) == 32'h0) else $error("misc reserved bits set");
	AST_MC2_RSV: assert property (reg_rd && reg_addr == OFS_MISC_CONTROL_SECOND
		|=> (reg_rdata & 32'hFFC0_FC00) == 32'h0) else $error("misc2 reserved bits set");
	AST_UNMAPPED: assert property (reg_rd && reg_addr > 8'h14 |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	// a write read back two cycles later returns the writable misc bits and misc2 bits 1 to 9
	AST_MC2_RB: assert property (reg_wr && reg_addr == OFS_MISC_CONTROL_SECOND ##2
		reg_rd && reg_addr == OFS_MISC_CONTROL_SECOND
		|=> ((reg_rdata ^ $past(reg_wdata, 3)) & 32'h0000_03FE) == 32'h0)
		else $error("misc2 readback wrong");
	AST_MC_RB: assert property (reg_wr && reg_addr == OFS_MISC_CONTROL ##2
		reg_rd && reg_addr == OFS_MISC_CONTROL
		|=> ((reg_rdata ^ $past(reg_wdata, 3)) & 32'h0000_0F1C) == 32'h0)
		else $error("misc readback wrong");
	// local reset output follows pci reset and the software bit
	AST_LRO_PCI: assert property ($fell(pci_reset_n) |-> ##[1:4] !local_reset_output_n)
		else $error("pci reset not passed on");
	AST_SWRST: assert property (reg_wr && reg_addr == OFS_MISC_CONTROL
		&& reg_wdata[MC_SW_RESET] |-> ##[1:3] !local_reset_output_n)
		else $error("software reset not driven");
endmodule // bsm_link_properties

// ===== bench/test_bridge_strap_misc_control.sv
// self-checking bench: host and device joined through the link
`timescale 1ns/1ps
module test_bridge_strap_misc_control import bsm_pkg::*;;
	logic        ref_clk_in, resetn_in, pci_reset_req_in, local_reset_req_in, type40_mode_in;
	logic        bus_master_strap_in, arbiter_enable_in, pci_disable_in, eeprom_fitted_in;
	logic        cmd_wr_in, cmd_rd_in, init_busy_out, local_reset_seen_out;
	logic [1:0]  test_mode_req_in, test_mode_out, image_big_endian_out;
	logic [1:0]  image_local_burst_out, retry_limit_out;
	logic [7:0]  cmd_addr_in;
	logic [31:0] cmd_wdata_in, cmd_rdata_out;
	bsm_proto_t  protocol_out;
	logic        eeprom_use_out, initiator_enable_out, arbiter_enable_out, target_retry_out;
	logic        master_abort_response_out, hold_local_bus_out, slow_target_disconnect_out;
	logic        target_abort_error_out, single_beat_prefetch_out, ordering_rule_disable_out;
	logic        own_priority_out, park_enable_out;
	logic [11:0] image_prefetch_count_out;
	logic [3:0]  master_priority_out;
	logic [2:0]  parked_master_out;
	int          fail_count, comparisons;
	////////////////////////////////////////////////////////////////////////
	// both ends face each other; the checker watches the wires
	bsm_link_if lnk();
	bsm_host u_bsm_host (.link(lnk), .*);
	bsm_device u_bsm_device (.link(lnk), .*);
	bsm_link_properties u_bsm_link_properties (.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in), .pci_reset_n(lnk.pci_reset_n),
		.local_reset_output_n(lnk.local_reset_output_n), .reg_addr(lnk.reg_addr),
		.reg_wdata(lnk.reg_wdata), .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd),
		.reg_rdata(lnk.reg_rdata));
	// 100 MHz clock
	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// waits end one step past the edge so flop outputs have settled
	task cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		cmd_addr_in <= a;
		cmd_wdata_in <= d;
		cmd_wr_in <= 1'b1;
		@(posedge ref_clk_in);
		cmd_wr_in <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk_in);
		cmd_addr_in <= a;
		cmd_rd_in <= 1'b1;
		@(posedge ref_clk_in);
		cmd_rd_in <= 1'b0;
		#1 chk(cmd_rdata_out, e);
	endtask
	// straps set together with the reset request and held until well after it ends
	task rst(input logic p, input logic [6:0] s);
		@(posedge ref_clk_in);
		{type40_mode_in, bus_master_strap_in, arbiter_enable_in, pci_disable_in,
			eeprom_fitted_in, test_mode_req_in} <= s;
		pci_reset_req_in <= p;
		local_reset_req_in <= !p;
		cyc(5);
		@(posedge ref_clk_in);
		pci_reset_req_in <= 1'b0;
		local_reset_req_in <= 1'b0;
		cyc(20);
	endtask
	task end_of_test;
		$display("mismatches %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{pci_reset_req_in, local_reset_req_in, type40_mode_in, bus_master_strap_in} = 4'h0;
		{arbiter_enable_in, pci_disable_in, eeprom_fitted_in, cmd_wr_in, cmd_rd_in} = 5'h00;
		{test_mode_req_in, cmd_addr_in, cmd_wdata_in} = 42'h0;
		{resetn_in, fail_count, comparisons} = 65'h0;
		repeat (3) @(posedge ref_clk_in);
		resetn_in <= 1'b1;
		rst(1'b1, 7'b1111100);
		chk(32'(protocol_out), 32'(BSM_PROTO_TYPE40));
		chk(32'({initiator_enable_out, arbiter_enable_out, target_retry_out,
			eeprom_use_out, test_mode_out}), 32'h3C);
		rd(8'h00, 32'h0000_1001);
		rd(8'h0C, 32'h0000_0004);
		rd(8'h08, 32'h0000_0200);
		wr(8'h04, 32'h0000_0000);
		rd(8'h04, 32'h0000_0001);
		wr(8'h04, 32'h0000_0001);
		rd(8'h04, 32'h0000_0000);
		chk(32'(target_retry_out), 32'h0);
		rst(1'b0, 7'b0000010);
		chk(32'({arbiter_enable_out, eeprom_use_out, test_mode_out}), 32'h2);
		chk(32'(protocol_out == BSM_PROTO_TYPE40), 32'h0);
		wr(8'h14, 32'h0000_0002);
		wr(8'h04, 32'h0000_0180);
		cyc(2);
		chk(32'({image_local_burst_out, single_beat_prefetch_out}), 32'h5);
		rst(1'b1, 7'b1000000);
		chk(32'(init_busy_out), 32'h0);
		rd(8'h0C, 32'h0000_0004);
		wr(8'h00, 32'h0000_0A14);
		rd(8'h00, 32'h0000_0A15);
		wr(8'h10, 32'h0000_0003);
		wr(8'h04, 32'h003F_03FE);
		rd(8'h04, 32'h003F_03FE);
		chk(32'(image_prefetch_count_out), 32'hFCA);
		chk(32'({hold_local_bus_out, retry_limit_out, slow_target_disconnect_out,
			target_abort_error_out, ordering_rule_disable_out, master_abort_response_out}),
			32'h7F);
		chk(32'({image_local_burst_out, single_beat_prefetch_out}), 32'h0);
		chk(32'(image_big_endian_out[0] ^ image_big_endian_out[1]), 32'h1);
		wr(8'h04, 32'h0000_0000);
		cyc(2);
		chk(32'(image_prefetch_count_out), 32'h28A);
		wr(8'h08, 32'h0000_7D0F);
		rd(8'h08, 32'h0000_750F);
		chk(32'({master_priority_out, own_priority_out, park_enable_out,
			parked_master_out}), 32'h1FF);
		rd(8'h40, 32'h0000_0000);
		wr(8'h00, 32'h0000_0008);
		cyc(6);
		chk(32'(local_reset_seen_out), 32'h1);
		wr(8'h00, 32'h0000_0000);
		cyc(6);
		chk(32'(local_reset_seen_out), 32'h0);
		end_of_test();
	end
	// watchdog: the sequence needs well under 1000 cycles
	initial begin
		#50000;
		fail_count++;
		end_of_test();
	end
endmodule // test_bridge_strap_misc_control
